// *** hdl/lie_engine.sv ***
`timescale 1ns/1ns
`default_nettype none
module lie_engine
  import lie_pkg::*;
#(
  parameter int unsigned PC_W = LIE_PC_W,
  parameter int unsigned PULSE_MAX = LIE_PULSE_MAX
) (
  // clock, reset, freeze
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  // scan control and status
  input wire logic run_i,
  output logic scan_done_o,
  output logic prog_err_o,
  output logic gate_off_o,
  // io image
  input wire logic [LIE_IN_W-1:0] in_bits_i,
  output logic [LIE_OUT_W-1:0] out_bits_o,
  // program editing, honoured only while halted
  input wire lie_edit_t edit_i,
  input wire logic [PC_W-1:0] edit_addr_i,
  input wire logic [LIE_WORD_W-1:0] edit_data_i
);
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} lie_state_t;

  lie_state_t state_ff, nxt_state;
  logic [PC_W-1:0] pc_ff, nxt_pc;
  logic rr_ff, nxt_rr;
  logic [LIE_STACK_D-1:0] stk_ff, nxt_stk;
  logic gate_ff, nxt_gate;
  logic region_ff, nxt_region;
  logic line_new_ff, nxt_line_new;
  logic [LIE_PCNT_W-1:0] pcnt_ff, nxt_pcnt;
  logic err_ff, nxt_err;
  logic done_ff;
  logic [LIE_BITS-1:0] bits_ff;
  logic [LIE_OUT_W-1:0] out_ff;

  wire logic [LIE_WORD_W-1:0] instr_w;
  wire logic edge_prev_w;

  // decode
  wire logic fetch_w = en_i && (state_ff == ST_FETCH);
  wire logic exec_w = en_i && (state_ff == ST_EXEC);
  wire logic [LIE_OP_W-1:0] op_w = instr_w[LIE_WORD_W-1 -: LIE_OP_W];
  wire logic [LIE_ADDR_W-1:0] baddr_w = instr_w[LIE_ADDR_W-1:0];
  wire logic src_w = bits_ff[baddr_w];
  wire logic eff_w = rr_ff & gate_ff; // [RULE_03]
  wire logic is_pulse_w = lie_is_pulse(op_w);
  wire logic pulse_ok_w = pcnt_ff < LIE_PCNT_W'(PULSE_MAX); // [RULE_11]
  wire logic [LIE_PIDX_W-1:0] pidx_w = pcnt_ff[LIE_PIDX_W-1:0];
  wire logic writable_w = baddr_w >= LIE_ADDR_W'(LIE_IN_W);
  wire logic is_out_w = (op_w == LIE_OP_OUT) || (op_w == LIE_OP_OUTN);
  wire logic is_keep_w = op_w == LIE_OP_KEEP;
  wire logic is_step_w = (op_w == LIE_OP_STEP) || (op_w == LIE_OP_ADV);

  // bit-control results; a pulse shows only on the scan after its edge
  wire logic rise_val_w = eff_w & ~edge_prev_w; // [RULE_08] [RULE_10]
  wire logic fall_val_w = ~eff_w & edge_prev_w; // [RULE_09] [RULE_10]
  // top of stack holds the set line, rr the reset line
  wire logic keep_val_w = rr_ff ? 1'b0 : (stk_ff[0] ? 1'b1 : src_w); // [RULE_12] [RULE_13] [RULE_15]

  // latch inside a closed region is left alone
  wire logic bit_wr_w = exec_w && writable_w
    && (is_out_w || (is_pulse_w && pulse_ok_w) || (is_keep_w && gate_ff)); // [RULE_14]
  wire logic bit_val_w =
    (op_w == LIE_OP_OUT)  ? eff_w :
    (op_w == LIE_OP_OUTN) ? ~eff_w & gate_ff :
    (op_w == LIE_OP_RISE) ? rise_val_w :
    (op_w == LIE_OP_FALL) ? fall_val_w : keep_val_w;

  wire logic edge_wr_w = exec_w && is_pulse_w && pulse_ok_w; // [RULE_19]
  wire lie_edit_t edit_w = (state_ff == ST_IDLE) ? edit_i : LIE_EDIT_NONE;

  // stack helpers
  wire logic [LIE_STACK_D-1:0] push_w = {stk_ff[LIE_STACK_D-2:0], rr_ff};
  wire logic [LIE_STACK_D-1:0] pop_w = {1'b0, stk_ff[LIE_STACK_D-1:1]};

  lie_prog_mem #(
    .PC_W(PC_W)
  ) u_prog (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(en_i),
    .rd_en_i(fetch_w),
    .rd_addr_i(pc_ff),
    .rd_data_o(instr_w),
    .edit_i(edit_w),
    .edit_addr_i(edit_addr_i),
    .edit_data_i(edit_data_i)
  );

  lie_edge_mem #(
    .PIDX_W(LIE_PIDX_W)
  ) u_edge (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(en_i),
    .rd_en_i(fetch_w),
    .rd_idx_i(pidx_w),
    .rd_prev_o(edge_prev_w),
    .wr_en_i(edge_wr_w),
    .wr_idx_i(pidx_w),
    .wr_val_i(eff_w)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_rr = rr_ff;
    nxt_stk = stk_ff;
    nxt_gate = gate_ff;
    nxt_region = region_ff;
    nxt_line_new = line_new_ff;
    nxt_pcnt = pcnt_ff;
    nxt_err = err_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (run_i) begin
          nxt_state = ST_FETCH;
          nxt_pc = '0;
          nxt_gate = 1'b1;
          nxt_region = 1'b0;
          nxt_line_new = 1'b1;
          nxt_pcnt = '0;
        end
      end
      ST_FETCH: nxt_state = ST_EXEC;
      ST_EXEC: begin
        nxt_state = ST_FETCH;
        nxt_pc = pc_ff + 1'b1;
        if (!lie_is_load(op_w)) nxt_line_new = 1'b0;
        // unknown codes, timers and counters pass as no-ops here
        case (op_w)
          LIE_OP_LD, LIE_OP_LDN: begin
            // first load of a line starts afresh, later loads open a block
            if (!line_new_ff) nxt_stk = push_w;
            nxt_rr = (op_w == LIE_OP_LD) ? src_w : ~src_w;
            nxt_line_new = 1'b0;
          end
          // the branch point is not saved: conditions keep altering rr
          LIE_OP_AND: nxt_rr = rr_ff & src_w; // [RULE_16]
          LIE_OP_ANDN: nxt_rr = rr_ff & ~src_w; // [RULE_16]
          LIE_OP_OR: nxt_rr = rr_ff | src_w;
          LIE_OP_ORN: nxt_rr = rr_ff | ~src_w;
          LIE_OP_ANDLD: begin
            nxt_rr = rr_ff & stk_ff[0];
            nxt_stk = pop_w;
          end
          LIE_OP_ORLD: begin
            nxt_rr = rr_ff | stk_ff[0];
            nxt_stk = pop_w;
          end
          LIE_OP_OUT, LIE_OP_OUTN, LIE_OP_RISE, LIE_OP_FALL: begin
            nxt_line_new = 1'b1; // [RULE_17]
            if (is_pulse_w) begin
              if (pulse_ok_w) nxt_pcnt = pcnt_ff + 1'b1;
              else nxt_err = 1'b1; // [RULE_11]
            end
          end
          LIE_OP_KEEP: begin
            nxt_stk = pop_w; // [RULE_15]
            nxt_line_new = 1'b1; // [RULE_17]
          end
          LIE_OP_GATE: begin
            // nested gates only narrow; an inner OFF runs to the shared clear
            nxt_gate = eff_w; // [RULE_01] [RULE_05] [RULE_06] [RULE_20]
            nxt_region = 1'b1;
            nxt_line_new = 1'b1;
          end
          LIE_OP_CLEAR: begin
            // rr is not consulted: the clear carries no conditions
            nxt_gate = 1'b1; // [RULE_01] [RULE_04] [RULE_05] [RULE_20]
            nxt_region = 1'b0;
            nxt_line_new = 1'b1;
          end
          LIE_OP_STEP, LIE_OP_ADV: if (region_ff) nxt_err = 1'b1; // [RULE_07]
          LIE_OP_END: begin
            nxt_pc = '0;
            nxt_gate = 1'b1;
            nxt_region = 1'b0;
            nxt_line_new = 1'b1;
            nxt_pcnt = '0;
            nxt_state = run_i ? ST_FETCH : ST_IDLE;
          end
          default: ;
        endcase
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= ST_IDLE;
      pc_ff <= '0;
      rr_ff <= 1'b0;
      stk_ff <= '0;
      gate_ff <= 1'b1;
      region_ff <= 1'b0;
      line_new_ff <= 1'b1;
      pcnt_ff <= '0;
      err_ff <= 1'b0;
    end else if (en_i) begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      rr_ff <= nxt_rr;
      stk_ff <= nxt_stk;
      gate_ff <= nxt_gate;
      region_ff <= nxt_region;
      line_new_ff <= nxt_line_new;
      pcnt_ff <= nxt_pcnt;
      err_ff <= nxt_err;
    end
  end

  // inputs sampled once per scan so a scan sees one consistent image
  wire logic scan_edge_w = (exec_w && op_w == LIE_OP_END) || (en_i && state_ff == ST_IDLE);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bits_ff <= '0;
      out_ff <= '0;
      done_ff <= 1'b0;
    end else if (en_i) begin
      done_ff <= exec_w && op_w == LIE_OP_END;
      if (bit_wr_w) bits_ff[baddr_w] <= bit_val_w;
      if (scan_edge_w) begin
        bits_ff[LIE_IN_W-1:0] <= in_bits_i;
        out_ff <= bits_ff[LIE_OUT_BASE +: LIE_OUT_W];
      end
    end
  end

  assign scan_done_o = done_ff;
  assign prog_err_o = err_ff;
  assign gate_off_o = ~gate_ff; // [RULE_02]
  assign out_bits_o = out_ff;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // one-instruction strobes, so the checks below take $past of plain signals
  wire logic gate_exec_w = exec_w && (op_w == LIE_OP_GATE);
  wire logic clear_exec_w = exec_w && (op_w == LIE_OP_CLEAR);
  wire logic end_exec_w = exec_w && (op_w == LIE_OP_END);

  sequence rise_edge_s;
    exec_w && op_w == LIE_OP_RISE && bit_wr_w && eff_w && !edge_prev_w;
  endsequence
  sequence fall_edge_s;
    exec_w && op_w == LIE_OP_FALL && bit_wr_w && !eff_w && edge_prev_w;
  endsequence
  sequence scan_end_s;
    end_exec_w;
  endsequence
  sequence keep_both_s;
    exec_w && is_keep_w && writable_w && gate_ff && rr_ff && stk_ff[0];
  endsequence

  rise_on_a: assert property (rise_edge_s |=> bits_ff[$past(baddr_w)]) // [RULE_08]
    else $error("rise pulse missing after rising edge");
  rise_off_a: assert property ( // [RULE_10]
    exec_w && op_w == LIE_OP_RISE && bit_wr_w && edge_prev_w |=> !bits_ff[$past(baddr_w)])
    else $error("rise pulse lasted past one execution");
  fall_on_a: assert property (fall_edge_s |=> bits_ff[$past(baddr_w)]) // [RULE_09]
    else $error("fall pulse missing after falling edge");
  fall_hold_a: assert property ( // [RULE_09]
    exec_w && op_w == LIE_OP_FALL && bit_wr_w && eff_w |=> !bits_ff[$past(baddr_w)])
    else $error("fall pulse on while condition is on");
  keep_reset_a: assert property (keep_both_s |=> !bits_ff[$past(baddr_w)]) // [RULE_13]
    else $error("latch reset lost to set");
  keep_set_a: assert property ( // [RULE_12]
    exec_w && is_keep_w && writable_w && gate_ff && !rr_ff && stk_ff[0]
    |=> bits_ff[$past(baddr_w)])
    else $error("latch did not set");
  keep_frozen_a: assert property ( // [RULE_14]
    exec_w && is_keep_w && !gate_ff |=> $stable(bits_ff))
    else $error("latch changed inside closed region");
  out_gated_a: assert property ( // [RULE_03]
    exec_w && op_w == LIE_OP_OUT && bit_wr_w |=> bits_ff[$past(baddr_w)] == $past(eff_w))
    else $error("output not ANDed with gate");
  gate_narrow_a: assert property ( // [RULE_06]
    gate_exec_w |=> gate_ff == $past(eff_w) ##1 !(gate_ff && !$past(gate_ff)
    && !$past(clear_exec_w) && !$past(end_exec_w)))
    else $error("gate flag wrong after gate");
  gate_clear_a: assert property ( // [RULE_20]
    exec_w && op_w == LIE_OP_CLEAR |=> gate_ff && !region_ff)
    else $error("clear did not reopen execution");
  step_err_a: assert property (exec_w && is_step_w && region_ff |=> prog_err_o) // [RULE_07]
    else $error("step inside region not flagged");
  pulse_cap_a: assert property (exec_w && is_pulse_w && !pulse_ok_w |=> prog_err_o) // [RULE_11]
    else $error("pulse overflow not flagged");
  // a closed gate can only exist between a gate and its clear
  region_gate_a: assert property (!gate_ff |-> region_ff) // [RULE_20]
    else $error("gate closed outside a region");
  outn_closed_a: assert property ( // [RULE_02]
    exec_w && op_w == LIE_OP_OUTN && bit_wr_w && !gate_ff |=> !bits_ff[$past(baddr_w)])
    else $error("inverted output on inside closed region");
  scan_done_a: assert property (scan_end_s |=> scan_done_o)
    else $error("scan done missing after end");
endmodule
`default_nettype wire

// *** shared/lie_pkg.sv ***
// Functional notes
// RULE_01 - gate is code 02, clear is 03
// RULE_02 - gate off: timers reset, latches frozen, rest ignored; here OUT, RISE, FALL run with the line forced off and OUTN writes 0
// RULE_03 - gate on: every line ANDed with gate
// RULE_04 - clear line has no conditions; no operands
// RULE_05 - gates stack until clear; extra clears harmless
// RULE_06 - inner gate off gates through shared clear
// RULE_07 - no step instructions inside gated region
// RULE_08 - rise pulse on for one scan
// RULE_09 - fall pulse off until falling edge
// RULE_10 - next execution after pulse clears bit
// RULE_11 - at most 16 pulse instructions total
// RULE_12 - latch: first line sets, second clears
// RULE_13 - latch set and reset together: reset wins
// RULE_14 - latch holds state in gated-off region
// RULE_15 - latch lines coded before latch, set first
// RULE_16 - branch condition not saved; line runs through
// RULE_17 - bit-control instructions end a line
// RULE_18 - insert or delete renumbers later addresses
// RULE_19 - each pulse keeps previous condition state
// RULE_20 - one gate flag, forced on by clear
package lie_pkg;
  localparam int unsigned LIE_OP_W = 8;
  localparam int unsigned LIE_ADDR_W = 6;
  localparam int unsigned LIE_WORD_W = 16;
  localparam int unsigned LIE_PC_W = 6;
  localparam int unsigned LIE_BITS = 64;
  localparam int unsigned LIE_IN_W = 16;
  localparam int unsigned LIE_OUT_W = 16;
  localparam int unsigned LIE_OUT_BASE = 16;
  localparam int unsigned LIE_STACK_D = 8;
  localparam int unsigned LIE_PULSE_MAX = 16;
  localparam int unsigned LIE_PIDX_W = 4;
  localparam int unsigned LIE_PCNT_W = 5;
  localparam logic [LIE_WORD_W-1:0] LIE_WORD_RST = 16'h0000;
  // function-coded instructions
  localparam logic [LIE_OP_W-1:0] LIE_OP_NOP = 8'h00;
  localparam logic [LIE_OP_W-1:0] LIE_OP_END = 8'h01;
  localparam logic [LIE_OP_W-1:0] LIE_OP_GATE = 8'h02;
  localparam logic [LIE_OP_W-1:0] LIE_OP_CLEAR = 8'h03;
  localparam logic [LIE_OP_W-1:0] LIE_OP_STEP = 8'h04;
  localparam logic [LIE_OP_W-1:0] LIE_OP_ADV = 8'h05;
  localparam logic [LIE_OP_W-1:0] LIE_OP_RISE = 8'h10;
  localparam logic [LIE_OP_W-1:0] LIE_OP_FALL = 8'h11;
  localparam logic [LIE_OP_W-1:0] LIE_OP_KEEP = 8'h12;
  // key-entered instructions
  localparam logic [LIE_OP_W-1:0] LIE_OP_LD = 8'h80;
  localparam logic [LIE_OP_W-1:0] LIE_OP_LDN = 8'h81;
  localparam logic [LIE_OP_W-1:0] LIE_OP_AND = 8'h82;
  localparam logic [LIE_OP_W-1:0] LIE_OP_ANDN = 8'h83;
  localparam logic [LIE_OP_W-1:0] LIE_OP_OR = 8'h84;
  localparam logic [LIE_OP_W-1:0] LIE_OP_ORN = 8'h85;
  localparam logic [LIE_OP_W-1:0] LIE_OP_ANDLD = 8'h86;
  localparam logic [LIE_OP_W-1:0] LIE_OP_ORLD = 8'h87;
  localparam logic [LIE_OP_W-1:0] LIE_OP_OUT = 8'h88;
  localparam logic [LIE_OP_W-1:0] LIE_OP_OUTN = 8'h89;

  typedef enum logic [1:0] {LIE_EDIT_NONE, LIE_EDIT_WRITE, LIE_EDIT_INSERT, LIE_EDIT_DELETE}
    lie_edit_t;

  function automatic logic lie_is_pulse(input logic [LIE_OP_W-1:0] op);
    return (op == LIE_OP_RISE) || (op == LIE_OP_FALL);
  endfunction

  function automatic logic lie_is_load(input logic [LIE_OP_W-1:0] op);
    return (op == LIE_OP_LD) || (op == LIE_OP_LDN);
  endfunction
endpackage

// *** hdl/lie_prog_mem.sv ***
`timescale 1ns/1ns
`default_nettype none
module lie_prog_mem
  import lie_pkg::*;
#(
  parameter int unsigned PC_W = LIE_PC_W
) (
  // clock, reset, freeze
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  // fetch
  input wire logic rd_en_i,
  input wire logic [PC_W-1:0] rd_addr_i,
  output logic [LIE_WORD_W-1:0] rd_data_o,
  // editing
  input wire lie_edit_t edit_i,
  input wire logic [PC_W-1:0] edit_addr_i,
  input wire logic [LIE_WORD_W-1:0] edit_data_i
);
  localparam int unsigned DEPTH = 2 ** PC_W;
  logic [LIE_WORD_W-1:0] mem_ff [DEPTH];
  logic [LIE_WORD_W-1:0] rd_ff;
  wire logic [LIE_WORD_W-1:0] old_w = mem_ff[edit_addr_i];

  assign rd_data_o = rd_ff;

  // whole-array shift keeps addresses dense; costs a mux per word
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_ff <= LIE_WORD_RST;
      for (int i = 0; i < DEPTH; i++) mem_ff[i] <= LIE_WORD_RST;
    end else if (en_i) begin
      if (rd_en_i) rd_ff <= mem_ff[rd_addr_i];
      unique case (edit_i)
        LIE_EDIT_NONE: ;
        LIE_EDIT_WRITE: mem_ff[edit_addr_i] <= edit_data_i;
        LIE_EDIT_INSERT: begin // [RULE_18]
          for (int i = 1; i < DEPTH; i++) if (i > edit_addr_i) mem_ff[i] <= mem_ff[i-1];
          mem_ff[edit_addr_i] <= edit_data_i;
        end
        LIE_EDIT_DELETE: begin // [RULE_18]
          for (int i = 0; i < DEPTH - 1; i++) if (i >= edit_addr_i) mem_ff[i] <= mem_ff[i+1];
          mem_ff[DEPTH-1] <= LIE_WORD_RST;
        end
      endcase
    end
  end

  insert_shift_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE_18]
    en_i && edit_i == LIE_EDIT_INSERT && edit_addr_i != PC_W'(DEPTH - 1)
    |=> mem_ff[$past(edit_addr_i) + 1] == $past(old_w))
    else $error("insert did not move the following word up");
  delete_shift_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE_18]
    en_i && edit_i == LIE_EDIT_DELETE |=> mem_ff[DEPTH-1] == LIE_WORD_RST)
    else $error("delete left a stale last word");
endmodule
`default_nettype wire

// *** hdl/lie_edge_mem.sv ***
`timescale 1ns/1ns
`default_nettype none
module lie_edge_mem
  import lie_pkg::*;
#(
  parameter int unsigned PIDX_W = LIE_PIDX_W
) (
  // clock, reset, freeze
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic en_i,
  // read of previous condition
  input wire logic rd_en_i,
  input wire logic [PIDX_W-1:0] rd_idx_i,
  output logic rd_prev_o,
  // update with present condition
  input wire logic wr_en_i,
  input wire logic [PIDX_W-1:0] wr_idx_i,
  input wire logic wr_val_i
);
  localparam int unsigned N = 2 ** PIDX_W;
  logic [N-1:0] prev_ff;
  logic rd_ff;

  assign rd_prev_o = rd_ff;

  // one slot per pulse instance, in program order
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_ff <= '0;
      rd_ff <= 1'b0;
    end else if (en_i) begin
      if (rd_en_i) rd_ff <= prev_ff[rd_idx_i];
      if (wr_en_i) prev_ff[wr_idx_i] <= wr_val_i; // [RULE_19]
    end
  end

  edge_store_a: assert property (@(posedge clk_i) disable iff (!rstn_i) // [RULE_19]
    en_i && wr_en_i |=> prev_ff[$past(wr_idx_i)] == $past(wr_val_i))
    else $error("pulse condition not remembered");
endmodule
`default_nettype wire

// *** tb/ladder_interlock_edge_latch_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module ladder_interlock_edge_latch_tb;
  import lie_pkg::*;
  logic clk_i;
  logic rstn_i;
  logic en_i;
  logic run_i;
  logic scan_done_o;
  logic prog_err_o;
  logic gate_off_o;
  logic [LIE_IN_W-1:0] in_bits_i;
  logic [LIE_OUT_W-1:0] out_bits_o;
  lie_edit_t edit_i;
  logic [LIE_PC_W-1:0] edit_addr_i;
  logic [LIE_WORD_W-1:0] edit_data_i;
  int err_total;
  int checks;
  logic [LIE_WORD_W-1:0] prog[$];
  logic gate_seen;

  lie_engine lie_engine_inst (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .en_i(en_i),
    .run_i(run_i),
    .scan_done_o(scan_done_o),
    .prog_err_o(prog_err_o),
    .gate_off_o(gate_off_o),
    .in_bits_i(in_bits_i),
    .out_bits_o(out_bits_o),
    .edit_i(edit_i),
    .edit_addr_i(edit_addr_i),
    .edit_data_i(edit_data_i)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [15:0] iw(input logic [7:0] op, input int b);
    return {op, 8'(b)};
  endfunction

  task automatic summarize();
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic edit(input lie_edit_t k, input int a, input logic [15:0] d);
    @(negedge clk_i);
    edit_i = k;
    edit_addr_i = a[LIE_PC_W-1:0];
    edit_data_i = d;
    @(negedge clk_i);
    edit_i = LIE_EDIT_NONE;
  endtask

  task automatic load();
    for (int i = 0; i < prog.size(); i++) begin
      edit(LIE_EDIT_WRITE, i, prog[i]);
    end
  endtask

  // also notes whether the gate was seen closed during the scan
  task automatic wait_done();
    int n;
    n = 0;
    while (scan_done_o !== 1'b1 && n < 500) begin
      @(negedge clk_i);
      if (gate_off_o === 1'b1) gate_seen = 1'b1;
      n++;
    end
    if (n >= 500) begin
      err_total++;
      $display("[FAIL] scan_done_o expected 1 seen timeout");
      summarize();
    end
  endtask

  // one scan only: run_i drops before END so the engine returns to idle
  task automatic scan(input logic [15:0] inb);
    @(negedge clk_i);
    in_bits_i = inb;
    run_i = 1'b1;
    gate_seen = 1'b0;
    @(negedge clk_i);
    run_i = 1'b0;
    wait_done();
  endtask

  task automatic t_gate();
    prog = {iw(LIE_OP_LD, 0), iw(LIE_OP_GATE, 0), iw(LIE_OP_LD, 1), iw(LIE_OP_OUT, 16),
             iw(LIE_OP_LD, 2), iw(LIE_OP_OUTN, 17), iw(LIE_OP_CLEAR, 0), iw(LIE_OP_LD, 3),
             iw(LIE_OP_OUT, 18), iw(LIE_OP_AND, 4), iw(LIE_OP_OUT, 19), iw(LIE_OP_END, 0)};
    load();
    scan(16'h001b);
    chk("gate on outs", 16'h000f, out_bits_o & 16'h000f);
    chk("gate_off_o open region", 16'h0000, {15'h0, gate_seen});
    scan(16'h0008);
    chk("gate off outs", 16'h0004, out_bits_o & 16'h000f);
    chk("gate_off_o closed region", 16'h0001, {15'h0, gate_seen});
    chk("gate_off_o after end", 16'h0000, {15'h0, gate_off_o});
    scan(16'h0003);
    chk("branch not saved", 16'h0003, out_bits_o & 16'h000f);
  endtask

  task automatic t_nest();
    prog = {iw(LIE_OP_LD, 0), iw(LIE_OP_GATE, 0), iw(LIE_OP_LD, 1), iw(LIE_OP_OUT, 16),
             iw(LIE_OP_LD, 2), iw(LIE_OP_GATE, 0), iw(LIE_OP_LD, 3), iw(LIE_OP_OUT, 17),
             iw(LIE_OP_CLEAR, 0), iw(LIE_OP_CLEAR, 0), iw(LIE_OP_LD, 4), iw(LIE_OP_OUT, 18),
             iw(LIE_OP_END, 0)};
    load();
    scan(16'h001b);
    chk("inner gate off", 16'h0005, out_bits_o & 16'h0007);
    scan(16'h001f);
    chk("both gates on", 16'h0007, out_bits_o & 16'h0007);
    scan(16'h001e);
    chk("outer gate off", 16'h0004, out_bits_o & 16'h0007);
  endtask

  task automatic t_pulse();
    logic [15:0] sin[5];
    logic [15:0] sexp[5];
    sin = '{16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0000};
    sexp = '{16'h0000, 16'h0001, 16'h0000, 16'h0002, 16'h0000};
    prog = {iw(LIE_OP_LD, 0), iw(LIE_OP_RISE, 16), iw(LIE_OP_LD, 0), iw(LIE_OP_FALL, 17),
             iw(LIE_OP_END, 0)};
    load();
    for (int i = 0; i < 5; i++) begin
      scan(sin[i]);
      chk("pulse outs", sexp[i], out_bits_o & 16'h0003);
    end
  endtask

  task automatic t_latch();
    logic [15:0] sin[9];
    logic [15:0] sexp[9];
    // bit0 gate, bit1 set line, bit2 reset line
    sin = '{16'h3, 16'h1, 16'h5, 16'h3, 16'h7, 16'h3, 16'h4, 16'h0, 16'h5};
    sexp = '{16'h1, 16'h1, 16'h0, 16'h1, 16'h0, 16'h1, 16'h1, 16'h1, 16'h0};
    prog = {iw(LIE_OP_LD, 0), iw(LIE_OP_GATE, 0), iw(LIE_OP_LD, 1), iw(LIE_OP_LD, 2),
             iw(LIE_OP_KEEP, 16), iw(LIE_OP_CLEAR, 0), iw(LIE_OP_END, 0)};
    load();
    for (int i = 0; i < 9; i++) begin
      scan(sin[i]);
      chk("latch bit", sexp[i], out_bits_o & 16'h0001);
    end
  endtask

  task automatic t_edit();
    prog = {iw(LIE_OP_LD, 0), iw(LIE_OP_OUT, 16), iw(LIE_OP_END, 0)};
    load();
    edit(LIE_EDIT_INSERT, 1, iw(LIE_OP_AND, 1));
    scan(16'h0001);
    chk("after insert", 16'h0000, out_bits_o & 16'h0001);
    scan(16'h0003);
    chk("after insert", 16'h0001, out_bits_o & 16'h0001);
    edit(LIE_EDIT_DELETE, 1, 16'h0000);
    scan(16'h0001);
    chk("after delete", 16'h0001, out_bits_o & 16'h0001);
  endtask

  // a low enable mid-scan must stall the scan, not drop or repeat a step
  task automatic t_freeze();
    scan(16'h0000);
    chk("out before freeze", 16'h0000, out_bits_o & 16'h0001);
    @(negedge clk_i);
    in_bits_i = 16'h0001;
    run_i = 1'b1;
    @(negedge clk_i);
    run_i = 1'b0;
    en_i = 1'b0;
    repeat (20) @(negedge clk_i);
    chk("scan_done_o while frozen", 16'h0000, {15'h0, scan_done_o});
    chk("out while frozen", 16'h0000, out_bits_o & 16'h0001);
    en_i = 1'b1;
    wait_done();
    chk("out after freeze", 16'h0001, out_bits_o & 16'h0001);
  endtask

  // sticky error flag: only the reset in t_step clears it
  task automatic t_limit();
    prog = {};
    for (int i = 0; i < 16; i++) begin
      prog.push_back(iw(LIE_OP_LD, 0));
      prog.push_back(iw(LIE_OP_RISE, 16 + i));
    end
    prog.push_back(iw(LIE_OP_END, 0));
    load();
    scan(16'h0000);
    scan(16'h0001);
    chk("sixteen pulses", 16'hffff, out_bits_o);
    chk("prog_err_o at limit", 16'h0000, {15'h0, prog_err_o});
    edit(LIE_EDIT_WRITE, 32, iw(LIE_OP_LD, 0));
    edit(LIE_EDIT_WRITE, 33, iw(LIE_OP_RISE, 32));
    edit(LIE_EDIT_WRITE, 34, iw(LIE_OP_END, 0));
    scan(16'h0001);
    chk("pulses cleared", 16'h0000, out_bits_o);
    chk("prog_err_o over limit", 16'h0001, {15'h0, prog_err_o});
  endtask

  // reset lands in mid-scan; the program is lost with it and reloaded
  task automatic t_step();
    @(negedge clk_i);
    run_i = 1'b1;
    repeat (4) @(negedge clk_i);
    rstn_i = 1'b0;
    run_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rstn_i = 1'b1;
    chk("prog_err_o after reset", 16'h0000, {15'h0, prog_err_o});
    chk("out after mid-scan reset", 16'h0000, out_bits_o);
    prog = {iw(LIE_OP_LD, 0), iw(LIE_OP_STEP, 0), iw(LIE_OP_LD, 0), iw(LIE_OP_GATE, 0),
            iw(LIE_OP_LD, 1), iw(LIE_OP_OUT, 16), iw(LIE_OP_CLEAR, 0), iw(LIE_OP_END, 0)};
    load();
    scan(16'h0003);
    chk("out with step outside", 16'h0001, out_bits_o & 16'h0001);
    chk("prog_err_o step outside", 16'h0000, {15'h0, prog_err_o});
    edit(LIE_EDIT_INSERT, 5, iw(LIE_OP_ADV, 0));
    scan(16'h0003);
    chk("out with step inside", 16'h0001, out_bits_o & 16'h0001);
    chk("prog_err_o step inside", 16'h0001, {15'h0, prog_err_o});
  endtask

  initial begin
    err_total = 0;
    checks = 0;
    rstn_i = 1'b0;
    en_i = 1'b1;
    run_i = 1'b0;
    in_bits_i = 16'h0000;
    edit_i = LIE_EDIT_NONE;
    edit_addr_i = 6'h00;
    edit_data_i = 16'h0000;
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    rstn_i = 1'b1;
    chk("out after reset", 16'h0000, out_bits_o);
    t_gate();
    t_nest();
    t_pulse();
    t_latch();
    t_edit();
    t_freeze();
    t_limit();
    t_step();
    summarize();
  end
endmodule
`default_nettype wire
